/* uart_flow_pkg.sv */
// package: register map, command codes, rate tables and state types for the flow/baud block
package uart_flow_pkg;
    // register byte addresses (own map, one word each)
    localparam logic [7:0] ADDR_MODE1 = 8'h00;
    localparam logic [7:0] ADDR_MODE2 = 8'h04;
    localparam logic [7:0] ADDR_CLKSEL = 8'h20;
    localparam logic [7:0] ADDR_AUXCTL = 8'h0c;
    localparam logic [7:0] ADDR_COMMAND = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_TXDATA = 8'h18;
    localparam logic [7:0] ADDR_RXDATA = 8'h1c;
    // the toggle and test-a offsets are word indexes, four bytes apart
    localparam logic [7:0] IDX_TOGGLE = 8'h02;
    localparam logic [7:0] IDX_TESTA = 8'h0a;
    localparam logic [7:0] ADDR_TOGGLE = IDX_TOGGLE << 2;
    localparam logic [7:0] ADDR_TESTA = IDX_TESTA << 2;
    // field positions
    localparam int M1_RX_FLOW = 7;
    localparam int M1_PAR_HI = 4;
    localparam int M1_PAR_LO = 3;
    localparam int M2_TX_FLOW = 4;
    localparam int M2_TX_RTS = 5;
    localparam int AUX_BANK = 7;
    localparam logic [1:0] PAR_WAKE = 2'h3;
    // command field in bits 7:4, enables in 3:0
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_RX_RESET = 4'h4;
    localparam logic [3:0] CMD_TX_RESET = 4'h3;
    localparam logic [3:0] CMD_OUT_SET = 4'ha;
    localparam logic [3:0] CMD_OUT_CLR = 4'hb;
    localparam int CMD_RX_EN = 0;
    localparam int CMD_RX_DIS = 1;
    localparam int CMD_TX_EN = 2;
    localparam int CMD_TX_DIS = 3;
    localparam logic [3:0] CS_TIMER = 4'hd;
    localparam logic [3:0] CS_EXT16 = 4'he;
    localparam logic [3:0] CS_EXT1 = 4'hf;
    // 16x clock divisor from the 10 MHz core clock, baud*16
    localparam int CLK_HZ = 10000000;
    localparam int RX_FIFO_DEPTH = 3;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_DECERR = 2'h3;
    localparam logic [3:0] TX_START_TICKS = 4'h3;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_t;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_SHIFT} tx_state_t;

    // baud rate times 10 per code, bank, column (normal/test)
    function automatic int rate_x10(input logic [3:0] code, input logic bank, input logic test);
        int r;
        r = 96000;
        unique case (code)
            4'h0: r = test ? (bank ? 72000 : 48000) : (bank ? 750 : 500);
            4'h1: r = test ? 8800 : 1100;
            4'h2: r = test ? 10760 : 1345;
            4'h3: r = test ? (bank ? 144000 : 192000) : (bank ? 1500 : 2000);
            4'h4: r = test ? 288000 : 3000;
            4'h5: r = test ? 576000 : 6000;
            4'h6: r = test ? 1152000 : 12000;
            4'h7: r = bank ? 20000 : 10500;
            4'h8: r = test ? 576000 : 24000;
            4'h9: r = 48000;
            4'ha: r = test ? (bank ? 144000 : 576000) : (bank ? 18000 : 72000);
            4'hb: r = 96000;
            4'hc: r = bank ? 192000 : 384000;
            default: r = 96000;
        endcase
        return r;
    endfunction
endpackage

/* uart_flow_baud_control.sv */
// uart flow control, transmitter disable handling, rate selection and receiver reset
//
// Contract
// - clear_send_input_n low means transmission permitted.
// - with tx_flow_gate_enable, high input stops tx after current character.
// - with tx_flow_gate_enable clear, multi-purpose input is ignored.
// - receiver raises request when fifo full and fourth start bit seen.
// - rx_flow_output_enable gives receiver control of the general output pin.
// - transmitter may also control the pin; both controls may be on.
// - commands 1010 and 1011 set and clear the output register bit.
// - pin is NAND of output register bit and inverted receiver request.
// - enabling flow leaves register bit; disabling returns pin to it.
// - disable within 3/16 bit (16x) or one bit (1x) sends nothing.
// - underrun tx disabled right after one load sends nothing.
// - tx_fully_drained set while underrun and right after enable.
// - holding data moves to shifter in start bit; holding free at its end.
// - clock code plus rate bank selects rate from fixed table.
// - codes 1101 timer, 1110 external 16x, 1111 external 1x.
// - each read at address 2 toggles rate test mode.
// - access at address A forces 1x mode and test output nodes; here each write toggles test_a and a read only returns it.
// - receiver reset then enable keeps receiver programming.
// - parity bits 11 keep receiver partially enabled, bypassing disable/reset.
// - output register asserted by command, auto-reset by tx done or rx full; here out_bit stays set and only the pin goes high.
`timescale 1ns/1ps
module uart_flow_baud_control
    import uart_flow_pkg::*;
(
    input wire logic core_clk, // 10 MHz core clock
    input wire logic rstn, // async reset, active low
    input wire uart_flow_pkg::axi_req_t axi_req, // axi4-lite requests
    output uart_flow_pkg::axi_rsp_t axi_rsp, // axi4-lite answers
    input wire logic multi_purpose_input_pin, // clear_send_input_n pin
    input wire logic rxd, // serial input
    input wire logic ext_clk, // external rate clock pin
    input wire logic timer_tick, // 16x tick from counter/timer
    output logic txd, // serial output
    output logic general_output_pin, // request_send_output_n pin
    output logic tx_holding_free, // transmit holding register free
    output logic tx_fully_drained // transmitter empty
);
    import uart_flow_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        axi_rsp_t rsp;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [7:0] mode1;
        logic [7:0] mode2;
        logic [7:0] clksel;
        logic [7:0] auxctl;
        logic test_rate;
        logic test_a;
        logic out_bit;
        logic tx_en;
        logic rx_en;
        tx_state_t tx_st;
        logic hold_full;
        logic [7:0] hold;
        logic [9:0] shift;
        logic [3:0] bitcnt;
        logic [3:0] sub;
        logic [23:0] div_cnt;
        logic tick;
        logic [2:0] sync_mp;
        logic [2:0] sync_rx;
        logic [2:0] sync_ext;
        logic rx_busy;
        logic [3:0] rx_sub;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [1:0] fifo_cnt;
        logic [7:0] fifo0;
        logic rx_req;
        logic txd;
        logic pin;
        logic drained;
        logic hfree;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    function automatic logic [23:0] divisor(input logic [3:0] code, input logic bank, input logic test);
        int d;
        d = (CLK_HZ * 10) / (rate_x10(code, bank, test) * 16);
        return d[23:0];
    endfunction

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    logic wake;
    logic cts_ok;
    logic ext_rise;
    logic one_x;
    logic [7:0] cmd;
    logic do_write;
    logic do_read;
    logic [31:0] rd;
    logic [1:0] rresp;
    logic [23:0] dv;

    always_comb begin
        nxt_st = st_ff;
        wake = (st_ff.mode1[M1_PAR_HI:M1_PAR_LO] == PAR_WAKE);
        cts_ok = !st_ff.mode2[M2_TX_FLOW] || !st_ff.sync_mp[2];
        ext_rise = st_ff.sync_ext[2] && !st_ff.sync_ext[1] ? 1'b0 : (st_ff.sync_ext[1] && !st_ff.sync_ext[2]);
        one_x = st_ff.test_a || (st_ff.clksel[7:4] == CS_EXT1);
        cmd = 8'h00;
        rd = 32'h0;
        rresp = AXI_OKAY;
        dv = 24'h0;
        nxt_st.sync_mp = {st_ff.sync_mp[1:0], multi_purpose_input_pin};
        nxt_st.sync_rx = {st_ff.sync_rx[1:0], rxd};
        nxt_st.sync_ext = {st_ff.sync_ext[1:0], ext_clk};

        // rate tick generator
        nxt_st.tick = 1'b0;
        unique case (st_ff.clksel[7:4])
            CS_TIMER: nxt_st.tick = timer_tick;
            CS_EXT16, CS_EXT1: nxt_st.tick = ext_rise;
            default: begin
                dv = divisor(st_ff.clksel[7:4], st_ff.auxctl[AUX_BANK], st_ff.test_rate);
                if (st_ff.div_cnt >= dv - 24'h1) begin
                    nxt_st.div_cnt = 24'h0;
                    nxt_st.tick = 1'b1;
                end else begin
                    nxt_st.div_cnt = st_ff.div_cnt + 24'h1;
                end
            end
        endcase

        // bus slave
        if (axi_req.awvalid && !st_ff.aw_got) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !st_ff.w_got) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = axi_req.wdata;
        end
        nxt_st.rsp.awready = !nxt_st.aw_got && !st_ff.rsp.bvalid;
        nxt_st.rsp.wready = !nxt_st.w_got && !st_ff.rsp.bvalid;
        do_write = st_ff.aw_got && st_ff.w_got && !st_ff.rsp.bvalid;
        if (st_ff.rsp.bvalid && axi_req.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp = AXI_OKAY;
            unique case (st_ff.aw_addr)
                ADDR_MODE1: nxt_st.mode1 = st_ff.w_data[7:0];
                ADDR_MODE2: nxt_st.mode2 = st_ff.w_data[7:0];
                ADDR_CLKSEL: nxt_st.clksel = st_ff.w_data[7:0];
                ADDR_AUXCTL: nxt_st.auxctl = st_ff.w_data[7:0];
                ADDR_COMMAND: cmd = st_ff.w_data[7:0];
                ADDR_TXDATA: begin
                    nxt_st.hold = st_ff.w_data[7:0];
                    nxt_st.hold_full = 1'b1;
                    nxt_st.hfree = 1'b0;
                end
                ADDR_TESTA: nxt_st.test_a = !st_ff.test_a;
                default: nxt_st.rsp.bresp = AXI_DECERR;
            endcase
        end
        do_read = axi_req.arvalid && st_ff.rsp.arready;
        nxt_st.rsp.arready = !st_ff.rsp.rvalid && !do_read;
        if (st_ff.rsp.rvalid && axi_req.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
            nxt_st.rsp.arready = 1'b1;
        end
        if (do_read) begin
            unique case (axi_req.araddr)
                ADDR_MODE1: rd = {24'h0, st_ff.mode1};
                ADDR_MODE2: rd = {24'h0, st_ff.mode2};
                ADDR_CLKSEL: rd = {24'h0, st_ff.clksel};
                ADDR_AUXCTL: rd = {24'h0, st_ff.auxctl};
                ADDR_STATUS: rd = {24'h0, st_ff.test_a, st_ff.test_rate, st_ff.out_bit, st_ff.rx_req,
                                   st_ff.drained, st_ff.hfree, st_ff.fifo_cnt};
                ADDR_RXDATA: begin
                    rd = {24'h0, st_ff.fifo0};
                    if (st_ff.fifo_cnt != 2'h0) begin
                        nxt_st.fifo_cnt = st_ff.fifo_cnt - 2'h1;
                    end
                end
                ADDR_TOGGLE: nxt_st.test_rate = !st_ff.test_rate;
                ADDR_TESTA: rd = {31'h0, st_ff.test_a};
                default: rresp = AXI_DECERR;
            endcase
            nxt_st.rsp.rdata = rd;
            nxt_st.rsp.rresp = rresp;
            nxt_st.rsp.rvalid = 1'b1;
        end

        // commands; programming registers are never touched by resets
        if (cmd[7:4] == CMD_OUT_SET) begin
            nxt_st.out_bit = 1'b1;
        end
        if (cmd[7:4] == CMD_OUT_CLR) begin
            nxt_st.out_bit = 1'b0;
        end
        if (cmd[CMD_TX_EN]) begin
            nxt_st.tx_en = 1'b1;
            if (!st_ff.hold_full && st_ff.tx_st == TX_IDLE) begin
                nxt_st.drained = 1'b1;
            end
        end
        if (cmd[CMD_RX_EN]) begin
            nxt_st.rx_en = 1'b1;
        end
        if ((cmd[CMD_RX_DIS] || cmd[7:4] == CMD_RX_RESET) && !wake) begin
            nxt_st.rx_en = 1'b0;
            if (cmd[7:4] == CMD_RX_RESET) begin
                nxt_st.fifo_cnt = 2'h0;
                nxt_st.rx_busy = 1'b0;
                nxt_st.rx_req = 1'b0;
            end
        end

        // transmitter
        if (cmd[CMD_TX_DIS] || cmd[7:4] == CMD_TX_RESET) begin
            nxt_st.tx_en = 1'b0;
            // a character in the first TX_START_TICKS ticks of its start bit (TX_START) is dropped, as is an unstarted load
            if (st_ff.tx_st != TX_SHIFT) begin
                nxt_st.tx_st = TX_IDLE;
                nxt_st.hold_full = 1'b0;
                nxt_st.hfree = 1'b1;
                nxt_st.txd = 1'b1;
                nxt_st.drained = 1'b1;
            end
        end else if (st_ff.tick) begin
            unique case (st_ff.tx_st)
                TX_IDLE: begin
                    if (st_ff.tx_en && st_ff.hold_full && cts_ok) begin
                        nxt_st.tx_st = TX_START;
                        nxt_st.txd = 1'b0;
                        nxt_st.drained = 1'b0;
                        nxt_st.sub = 4'h0;
                    end else if (!st_ff.hold_full) begin
                        nxt_st.drained = 1'b1;
                    end
                end
                TX_START: begin
                    nxt_st.sub = st_ff.sub + 4'h1;
                    if (one_x || st_ff.sub == TX_START_TICKS - 4'h1) begin
                        // holding moves during the start bit, after the disable window
                        nxt_st.shift = {1'b1, st_ff.hold, 1'b0};
                        nxt_st.hold_full = 1'b0;
                        nxt_st.tx_st = TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    nxt_st.sub = st_ff.sub + 4'h1;
                    if (one_x || st_ff.sub == 4'hf) begin
                        nxt_st.sub = 4'h0;
                        if (st_ff.bitcnt == 4'h0) begin
                            nxt_st.hfree = 1'b1;
                        end
                        nxt_st.shift = {1'b1, st_ff.shift[9:1]};
                        nxt_st.txd = st_ff.shift[1];
                        nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
                        if (st_ff.bitcnt == 4'h9) begin
                            nxt_st.bitcnt = 4'h0;
                            nxt_st.txd = 1'b1;
                            nxt_st.tx_st = TX_IDLE;
                        end
                    end
                end
            endcase
        end

        // receiver, 16x oversampling, fifo of RX_FIFO_DEPTH plus shifter
        if (st_ff.tick && (st_ff.rx_en || wake)) begin
            if (!st_ff.rx_busy) begin
                if (!st_ff.sync_rx[2]) begin
                    nxt_st.rx_busy = 1'b1;
                    nxt_st.rx_sub = 4'h0;
                    nxt_st.rx_bit = 4'h0;
                    if (st_ff.fifo_cnt == 2'(RX_FIFO_DEPTH)) begin
                        nxt_st.rx_req = 1'b1;
                    end
                end
            end else begin
                nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
                if (one_x || st_ff.rx_sub == 4'h7) begin
                    nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
                    if (st_ff.rx_bit != 4'h0) begin
                        nxt_st.rx_sh = {st_ff.sync_rx[2], st_ff.rx_sh[7:1]};
                    end
                    if (st_ff.rx_bit == 4'h9) begin
                        nxt_st.rx_busy = 1'b0;
                        // count on from the next value so a read in the same cycle is not lost
                        if (nxt_st.fifo_cnt != 2'(RX_FIFO_DEPTH)) begin
                            nxt_st.fifo_cnt = nxt_st.fifo_cnt + 2'h1;
                            nxt_st.fifo0 = st_ff.rx_sh;
                        end
                    end
                end
                if (st_ff.rx_sub == 4'hf) begin
                    nxt_st.rx_sub = 4'h0;
                end
            end
        end
        if (st_ff.rx_req && st_ff.fifo_cnt != 2'(RX_FIFO_DEPTH)) begin
            nxt_st.rx_req = 1'b0;
        end

        // output pin: nand of register bit and the inverted automatic requests
        nxt_st.pin = !(st_ff.out_bit
                       && !(st_ff.mode1[M1_RX_FLOW] && st_ff.rx_req)
                       && !(st_ff.mode2[M2_TX_RTS] && st_ff.drained));
        if (st_ff.test_a) begin
            nxt_st.pin = st_ff.tick;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.sync_mp <= 3'h7;
            st_ff.sync_rx <= 3'h7;
            st_ff.txd <= 1'b1;
            st_ff.pin <= 1'b1;
            st_ff.hfree <= 1'b1;
            st_ff.drained <= 1'b1;
            st_ff.rsp.arready <= 1'b1;
            st_ff.rsp.awready <= 1'b1;
            st_ff.rsp.wready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign axi_rsp = st_ff.rsp;
    assign txd = st_ff.txd;
    assign general_output_pin = st_ff.pin;
    assign tx_holding_free = st_ff.hfree;
    assign tx_fully_drained = st_ff.drained;
endmodule

/* remote_peer.sv */
// remote uart model: serial sender on the block's receive line and clear-to-send source
`timescale 1ns/1ps
module remote_peer #(parameter int BIT_CYC = 256) (
    input wire logic core_clk, // core clock
    input wire logic rts_n, // request from the block, high means hold off
    output logic ser_out, // serial line into the block
    output logic cts_n // clear-to-send into the block
);
    // ****************************************
    // line idle and sender
    // ****************************************
    initial begin
        ser_out = 1'b1;
        cts_n = 1'b0;
    end
    task automatic set_cts(input logic v);
        @(posedge core_clk) cts_n <= v;
    endtask
    // the remote sender only opens a character while the block's request is low
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        int i;
        f = {1'b1, b, 1'b0};
        for (i = 0; i < 3000 && rts_n === 1'b1; i++) @(posedge core_clk);
        if (rts_n === 1'b1) tb_top.no_answer("remote sender held off");
        for (i = 0; i < 10 * BIT_CYC; i++) @(posedge core_clk) ser_out <= f[i / BIT_CYC];
        @(posedge core_clk) ser_out <= 1'b1;
    endtask
endmodule

/* uart_flow_props.sv */
// port assertions for the flow/baud block
`timescale 1ns/1ps
module uart_flow_props
    import uart_flow_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rstn, // reset, active low
    input wire uart_flow_pkg::axi_req_t axi_req, // bus requests
    input wire uart_flow_pkg::axi_rsp_t axi_rsp, // bus answers
    input wire logic multi_purpose_input_pin, // clear-to-send
    input wire logic rxd, // serial in
    input wire logic ext_clk, // external clock
    input wire logic timer_tick, // timer tick
    input wire logic txd, // serial out
    input wire logic general_output_pin, // request pin
    input wire logic tx_holding_free, // holding register free
    input wire logic tx_fully_drained // transmitter empty
);
    // ****************************************
    // sequences and properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_taken;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    sequence s_start_bit;
        !tx_holding_free ##1 !tx_holding_free;
    endsequence
    property p_reset_vals;
        $rose(rstn) |-> txd && general_output_pin && tx_holding_free && tx_fully_drained;
    endproperty
    property p_wr_answer;
        s_wr_taken |-> ##[1:3] axi_rsp.bvalid;
    endproperty
    property p_rd_answer;
        s_rd_taken |=> axi_rsp.rvalid;
    endproperty
    property p_r_once;
        axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid;
    endproperty
    property p_busy_refuse;
        axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready;
    endproperty
    property p_decerr;
        s_rd_taken ##0 (axi_req.araddr == 8'h3c) |=> axi_rsp.rresp == AXI_DECERR;
    endproperty
    property p_idle_high;
        tx_fully_drained |-> txd;
    endproperty
    property p_start_hold;
        $fell(txd) && $past(tx_fully_drained) |-> s_start_bit;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset values");
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_r_once: assert property (p_r_once) else $error("read answered twice");
    a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while answer pending");
    a_decerr: assert property (p_decerr) else $error("unmapped read not refused");
    a_idle_high: assert property (p_idle_high) else $error("line low while transmitter empty");
    a_start_hold: assert property (p_start_hold) else $error("holding free during start bit");
endmodule
bind uart_flow_baud_control uart_flow_props u_props (.core_clk(core_clk), .rstn(rstn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .multi_purpose_input_pin(multi_purpose_input_pin), .rxd(rxd), .ext_clk(ext_clk),
    .timer_tick(timer_tick), .txd(txd), .general_output_pin(general_output_pin),
    .tx_holding_free(tx_holding_free), .tx_fully_drained(tx_fully_drained));

/* tb_top.sv */
// testbench for the flow/baud block: register sequences, transmit gating and receive flow
`timescale 1ns/1ps
module tb_top;
    import uart_flow_pkg::*;
    logic core_clk;
    logic rstn;
    logic tick = 1'b0;
    logic [3:0] tdiv = 4'h0;
    axi_req_t req;
    axi_rsp_t rsp;
    logic txd, pin, hfree, drained, ser, cts_n;
    logic [31:0] rdv;
    logic [1:0] resp;
    int num_errors = 0;
    int n_compared = 0;
    int k;
    int at;
    uart_flow_baud_control u_dut (.core_clk(core_clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp),
        .multi_purpose_input_pin(cts_n), .rxd(ser), .ext_clk(1'b0), .timer_tick(tick), .txd(txd),
        .general_output_pin(pin), .tx_holding_free(hfree), .tx_fully_drained(drained));
    remote_peer #(.BIT_CYC(256)) u_peer (.core_clk(core_clk), .rts_n(pin), .ser_out(ser), .cts_n(cts_n));
    // ****************************************
    // clock, rate tick and helpers
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // one tick in sixteen cycles keeps a bit at 256 cycles so frames stay short
    always @(posedge core_clk) begin
        tdiv <= tdiv + 4'h1;
        tick <= (tdiv == 4'hf);
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic no_answer(input string what);
        num_errors++;
        $display("MISMATCH %s expected answer seen none", what);
        complete_run();
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        int i;
        logic got;
        got = 1'b0;
        req.awaddr <= a;
        req.wdata <= {24'h0, d};
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (i = 0; i < 50 && !got; i++) begin
            @(posedge core_clk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                resp = rsp.bresp;
                req.bready <= 1'b0;
                got = 1'b1;
            end
        end
        if (!got) no_answer("write");
        @(posedge core_clk);
    endtask
    task automatic bus_rd(input logic [7:0] a);
        int i;
        logic got;
        got = 1'b0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (i = 0; i < 50 && !got; i++) begin
            @(posedge core_clk);
            if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                rdv = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
                got = 1'b1;
            end
        end
        if (!got) no_answer("read");
        @(posedge core_clk);
    endtask
    task automatic first_low(input int n);
        int i;
        at = -1;
        for (i = 0; i < n && at < 0; i++) begin
            @(posedge core_clk);
            if (txd !== 1'b1) at = i;
        end
    endtask
    task automatic wait_drained();
        int i;
        for (i = 0; i < 8000 && drained !== 1'b1; i++) @(posedge core_clk);
        if (drained !== 1'b1) no_answer("drained");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        req = '0;
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        bus_rd(ADDR_STATUS);
        chk("status after reset", 32'h0000000c, rdv);
        for (k = 0; k < 2; k++) begin
            bus_wr(ADDR_COMMAND, {(k == 0) ? CMD_OUT_SET : CMD_OUT_CLR, 4'h0});
            bus_rd(ADDR_STATUS);
            chk("output bit", (k == 0), rdv[5]);
            chk("output pin", (k == 1), pin);
        end
        for (k = 1; k >= 0; k--) begin
            bus_rd(ADDR_TOGGLE);
            bus_rd(ADDR_STATUS);
            chk("rate test mode", k, rdv[6]);
            bus_wr(ADDR_TESTA, 8'h01);
            bus_rd(ADDR_STATUS);
            chk("test a mode", k, rdv[7]);
        end
        bus_rd(8'h3c);
        chk("unmapped read resp", AXI_DECERR, resp);
        bus_wr(8'h3c, 8'h00);
        chk("unmapped write resp", AXI_DECERR, resp);
        bus_wr(ADDR_CLKSEL, {CS_TIMER, 4'h0});
        bus_wr(ADDR_COMMAND, 8'h04);
        bus_wr(ADDR_TXDATA, 8'h55);
        bus_wr(ADDR_COMMAND, 8'h08);
        first_low(3000);
        chk("line after quick disable", -1, at);
        bus_rd(ADDR_STATUS);
        chk("drained after disable", 1, rdv[3]);
        u_peer.set_cts(1'b1);
        bus_wr(ADDR_COMMAND, 8'h04);
        bus_wr(ADDR_TXDATA, 8'h5a);
        first_low(600);
        chk("ungated transmit starts", 1, at >= 0);
        wait_drained();
        bus_wr(ADDR_MODE2, 8'h10);
        bus_wr(ADDR_TXDATA, 8'h5a);
        first_low(1500);
        chk("gated transmit held", -1, at);
        u_peer.set_cts(1'b0);
        first_low(600);
        chk("transmit after clear", 1, at >= 0);
        repeat (128) @(posedge core_clk);
        chk("holding free in start bit", 0, hfree);
        repeat (256) @(posedge core_clk);
        chk("holding free after start bit", 1, hfree);
        bus_wr(ADDR_COMMAND, 8'h08);
        chk("late disable keeps character", 0, drained);
        wait_drained();
        bus_wr(ADDR_COMMAND, {CMD_OUT_SET, 4'h1});
        bus_wr(ADDR_MODE1, 8'h80);
        bus_rd(ADDR_STATUS);
        chk("output bit kept", 1, rdv[5]);
        for (k = 0; k < 4; k++) begin
            chk("request before full", 0, pin);
            u_peer.send_byte(8'hff);
        end
        chk("request after fourth start", 1, pin);
        bus_rd(ADDR_STATUS);
        chk("fifo count", 3, rdv[1:0]);
        bus_wr(ADDR_MODE1, 8'h00);
        chk("pin back to output bit", 0, pin);
        bus_wr(ADDR_MODE1, 8'h98);
        bus_wr(ADDR_COMMAND, {CMD_RX_RESET, 4'h0});
        bus_rd(ADDR_STATUS);
        chk("fifo kept in wake-up", 3, rdv[1:0]);
        bus_wr(ADDR_MODE1, 8'h80);
        bus_wr(ADDR_COMMAND, {CMD_RX_RESET, 4'h0});
        bus_rd(ADDR_STATUS);
        chk("fifo after reset", 0, rdv[1:0]);
        bus_wr(ADDR_MODE1, 8'h98);
        bus_wr(ADDR_COMMAND, 8'h01);
        bus_rd(ADDR_MODE1);
        chk("mode after rx reset", 32'h00000098, rdv);
        complete_run();
    end
endmodule
